// ==== hw/pcs_pkg.sv ====
// Package for the port pin and clock select block.
// Assumes an 8-bit register port with a 4-bit word address.
package pcs_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// Register word addresses
	localparam logic [3:0] OFS_CLK_CTRL  = 4'h0;
	localparam logic [3:0] OFS_PORTD     = 4'h1;
	localparam logic [3:0] OFS_DPTR_Y    = 4'h2;
	localparam logic [3:0] OFS_PORTD_BIT = 4'h3;
	localparam logic [3:0] OFS_PORTA     = 4'h4;
	localparam logic [3:0] OFS_PORTA_IN  = 4'h5;
	localparam logic [3:0] OFS_PORTB     = 4'h6;
	localparam logic [3:0] OFS_PORTB_IN  = 4'h7;
	localparam logic [3:0] OFS_PORTC_IN  = 4'h8;
	localparam logic [3:0] OFS_FUNC_SEL  = 4'h9;
	localparam logic [3:0] OFS_PULLUP    = 4'ha;
	localparam logic [3:0] OFS_KEY_EN    = 4'hb;
	localparam logic [3:0] OFS_LCD_DUTY  = 4'hc;
	localparam logic [3:0] OFS_CYCLES    = 4'hd;

	// Field positions
	localparam int CLK_SRC_BIT  = 0;
	localparam int CLK_DIV_BIT  = 3;
	localparam int FUNC_SEG_BIT = 0;
	localparam int FUNC_XC_BIT  = 1;
	localparam int PIN_INT      = 5;
	localparam int PIN_XCIN     = 6;
	localparam int PIN_XCOUT    = 7;

	// Values after reset
	localparam logic [3:0] RST_CLK_CTRL = 4'h8;
	localparam logic [7:0] RST_PORTD    = 8'hff;
	localparam logic [3:0] RST_PORT4    = 4'hf;
	localparam logic [3:0] RST_PULLUP   = 4'h0;
	localparam logic [3:0] RST_KEY_EN   = 4'h0;
	localparam logic [1:0] RST_DUTY     = 2'h2;

	// Last counter values of the dividers
	localparam logic [1:0] SYS_DIV_LAST   = 2'h3;
	localparam logic [1:0] INSTR_DIV_LAST = 2'h2;

	typedef enum logic [1:0] {
		PCS_DUTY_2 = 2'b00,
		PCS_DUTY_3 = 2'b01,
		PCS_DUTY_4 = 2'b10
	} pcs_duty_e;
endpackage

// ==== hw/pcs_sync.sv ====
// Two-flop synchroniser, one stage pair per bit.
// Assumes asynchronous pins; reset shows them at the released, pulled-up level.
`timescale 1ns/10ps
module pcs_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// First stage is read only by the second
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					// High, so idle pins raise no false key or reset report
					meta_q[i]   <= 1'b1;
					sync_out[i] <= 1'b1;
				end else begin
					meta_q[i]   <= async_in[i];
					sync_out[i] <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule

// ==== hw/pcs_clk_gen.sv ====
// System clock select and instruction clock divider, as one-cycle ticks.
// Assumes main_tick and sub_tick are single-cycle pulses on sys_clk.
`timescale 1ns/10ps
module pcs_clk_gen (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic main_tick,
	input  wire logic sub_tick,
	input  wire logic clock_source_sel,
	input  wire logic clock_divide_sel,
	output logic      sys_tick_q,
	output logic      instr_tick_q
);
	import pcs_pkg::*;

	logic       src_tick;
	logic       sys_tick_d;
	logic [1:0] div4_q;
	logic [1:0] div3_q;

	// Source pick and optional divide by four
	always_comb begin
		src_tick   = clock_source_sel ? sub_tick : main_tick;
		sys_tick_d = clock_divide_sel ? (src_tick && div4_q == SYS_DIV_LAST) : src_tick;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			div4_q <= 2'h0;
		else if (src_tick)
			div4_q <= div4_q + 2'h1;
	end

	// Instruction tick on every third system tick
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			div3_q       <= 2'h0;
			sys_tick_q   <= 1'b0;
			instr_tick_q <= 1'b0;
		end else begin
			sys_tick_q   <= sys_tick_d;
			instr_tick_q <= sys_tick_d && div3_q == INSTR_DIV_LAST;
			if (sys_tick_d)
				div3_q <= (div3_q == INSTR_DIV_LAST) ? 2'h0 : div3_q + 2'h1;
		end
	end
endmodule

// ==== hw/pcs_port_pins.sv ====
// Port pin logic and system clock selection for a small 4-bit controller.
// Assumes one clock; oscillators, pins and the reset pin arrive asynchronously.
//
// Summary of operation
// - Two control bits choose main or sub oscillator, undivided or divided by four.
// - Leaving reset, main oscillator divided by four is the system clock.
// - Instruction clock is the system clock divided by three.
// - Each instruction clock period counts as one machine cycle.
// - Reset pin pulled low on watchdog timeout or low supply; pull-up built in.
// - Each output port pin is its own open-drain bit.
// - Two output pins may serve the sub oscillator instead of port use.
// - Bidirectional pins with latch one act as inputs, readable as data.
// - Port A always has wakeup and pull-up; port B has both by software.
// - Input port C shares its pins with four LCD segment outputs.
// - Common lines driven per duty: two, three or four.
// - Per-pin control bit switches port B pull-up on at one, off at zero.
// - Open-drain pins stay released after reset until a zero is written.
// - Carrier output is a dedicated push-pull pin.
// - Bit set, clear and test on port D use the low data pointer.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module pcs_port_pins (
	input  wire logic                        sys_clk,
	input  wire logic                        sys_rst,
	input  wire logic [pcs_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [pcs_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [pcs_pkg::DATA_W-1:0]  reg_rdata,
	input  wire logic                        osc_main_pin,
	output logic                             system_clk,
	output logic                             instr_clk,
	output logic      [7:0]                  machine_cycles,
	input  wire logic                        wdt_timeout,
	input  wire logic                        low_supply,
	input  wire logic                        reset_pin_in,
	output logic                             reset_pin_out,
	output logic                             reset_pin_oe_n,
	output logic                             reset_pin_pullup,
	output logic                             ext_reset_req,
	input  wire logic [7:0]                  out_port_pins_in,
	output logic      [7:0]                  out_port_pins_out,
	output logic      [7:0]                  out_port_pins_oe_n,
	output logic                             ext_int_level,
	input  wire logic [3:0]                  io_port_a_in,
	output logic      [3:0]                  io_port_a_out,
	output logic      [3:0]                  io_port_a_oe_n,
	output logic      [3:0]                  io_port_a_pullup,
	input  wire logic [3:0]                  io_port_b_in,
	output logic      [3:0]                  io_port_b_out,
	output logic      [3:0]                  io_port_b_oe_n,
	output logic      [3:0]                  io_port_b_pullup,
	output logic                             key_wakeup,
	input  wire logic [3:0]                  in_port_c_in,
	input  wire logic [3:0]                  seg_drive,
	output logic      [3:0]                  shared_lcd_segments,
	output logic      [3:0]                  shared_lcd_segments_oe_n,
	input  wire logic [3:0]                  com_drive,
	output logic      [3:0]                  lcd_common_lines,
	output logic      [3:0]                  lcd_common_en,
	input  wire logic                        carrier_in,
	output logic                             carrier_out
);
	import pcs_pkg::*;

	// Control registers
	logic [3:0] clock_ctrl_reg_q;
	logic [7:0] portd_q;
	logic [2:0] dptr_y_q;
	logic [3:0] porta_q;
	logic [3:0] portb_q;
	logic       seg_mode_q;
	logic       xc_mode_q;
	logic [3:0] pullup_ctrl_bit_q;
	logic [3:0] key_en_q;
	logic [1:0] duty_q;

	// Synchronised pins and edge history
	logic       main_s;
	logic       main_prev_q;
	logic       rst_pin_s;
	logic [7:0] d_s;
	logic [3:0] a_s;
	logic [3:0] b_s;
	logic [3:0] c_s;
	logic       sub_prev_q;
	logic       main_tick;
	logic       sub_tick;
	logic       sys_tick;
	logic       instr_tick;
	logic [7:0] rdata_d;
	logic [3:0] key_hit;

	wire logic clock_source_sel = clock_ctrl_reg_q[CLK_SRC_BIT];
	wire logic clock_divide_sel = clock_ctrl_reg_q[CLK_DIV_BIT];

	function automatic logic [3:0] duty_mask(input logic [1:0] duty);
		case (duty)
			PCS_DUTY_2: duty_mask = 4'h3;
			PCS_DUTY_3: duty_mask = 4'h7;
			PCS_DUTY_4: duty_mask = 4'hf;
			default:    duty_mask = 4'hf;
		endcase
	endfunction

	pcs_sync #(.W(1)) u_sync_main (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in (osc_main_pin),
		.sync_out (main_s)
	);

	pcs_sync #(.W(1)) u_sync_rst (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in (reset_pin_in),
		.sync_out (rst_pin_s)
	);

	pcs_sync #(.W(20)) u_sync_ports (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in ({out_port_pins_in, io_port_a_in, io_port_b_in, in_port_c_in}),
		.sync_out ({d_s, a_s, b_s, c_s})
	);

	// Oscillator edges become ticks; sub clock only exists in crystal mode
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			main_prev_q <= 1'b1; // Matches the synchroniser reset; no false tick
			sub_prev_q  <= 1'b0;
		end else begin
			main_prev_q <= main_s;
			sub_prev_q  <= d_s[PIN_XCIN] & xc_mode_q;
		end
	end

	assign main_tick = main_s & ~main_prev_q;
	assign sub_tick  = d_s[PIN_XCIN] & xc_mode_q & ~sub_prev_q;

	pcs_clk_gen u_clk_gen (
		.sys_clk          (sys_clk),
		.sys_rst          (sys_rst),
		.main_tick        (main_tick),
		.sub_tick         (sub_tick),
		.clock_source_sel (clock_source_sel),
		.clock_divide_sel (clock_divide_sel),
		.sys_tick_q       (sys_tick),
		.instr_tick_q     (instr_tick)
	);

	// Clock control; reset value picks main divided by four
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			clock_ctrl_reg_q <= RST_CLK_CTRL;
		else if (reg_wr && reg_addr == OFS_CLK_CTRL)
			clock_ctrl_reg_q <= reg_wdata[3:0];
	end

	// Clock ticks out, and one machine cycle per instruction tick
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			system_clk     <= 1'b0;
			instr_clk      <= 1'b0;
			machine_cycles <= 8'h00;
		end else begin
			system_clk <= sys_tick;
			instr_clk  <= instr_tick;
			if (instr_tick)
				machine_cycles <= machine_cycles + 8'h01;
		end
	end

	// Port D latch: whole-port write or single bit through the pointer
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			portd_q <= RST_PORTD;
		else if (reg_wr && reg_addr == OFS_PORTD)
			portd_q <= reg_wdata;
		else if (reg_wr && reg_addr == OFS_PORTD_BIT)
			portd_q[dptr_y_q] <= reg_wdata[0];
	end

	// Low data pointer selects the port D bit
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			dptr_y_q <= 3'h0;
		else if (reg_wr && reg_addr == OFS_DPTR_Y)
			dptr_y_q <= reg_wdata[2:0];
	end

	// Bidirectional port latches start released
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			porta_q <= RST_PORT4;
			portb_q <= RST_PORT4;
		end else begin
			if (reg_wr && reg_addr == OFS_PORTA)
				porta_q <= reg_wdata[3:0];
			if (reg_wr && reg_addr == OFS_PORTB)
				portb_q <= reg_wdata[3:0];
		end
	end

	// Pin function, pull-up, wakeup and duty selections
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			seg_mode_q        <= 1'b0;
			xc_mode_q         <= 1'b0;
			pullup_ctrl_bit_q <= RST_PULLUP;
			key_en_q          <= RST_KEY_EN;
			duty_q            <= RST_DUTY;
		end else begin
			if (reg_wr && reg_addr == OFS_FUNC_SEL) begin
				seg_mode_q <= reg_wdata[FUNC_SEG_BIT];
				xc_mode_q  <= reg_wdata[FUNC_XC_BIT];
			end
			if (reg_wr && reg_addr == OFS_PULLUP)
				pullup_ctrl_bit_q <= reg_wdata[3:0];
			if (reg_wr && reg_addr == OFS_KEY_EN)
				key_en_q <= reg_wdata[3:0];
			if (reg_wr && reg_addr == OFS_LCD_DUTY)
				duty_q <= reg_wdata[1:0];
		end
	end

	// Read mux; unmapped words and reserved bits read zero
	always_comb begin
		rdata_d = 8'h00;
		case (reg_addr)
			OFS_CLK_CTRL:  rdata_d = {4'h0, clock_ctrl_reg_q};
			OFS_PORTD:     rdata_d = portd_q;
			OFS_DPTR_Y:    rdata_d = {5'h00, dptr_y_q};
			OFS_PORTD_BIT: rdata_d = {7'h00, portd_q[dptr_y_q]};
			OFS_PORTA:     rdata_d = {4'h0, porta_q};
			OFS_PORTA_IN:  rdata_d = {4'h0, a_s & porta_q};
			OFS_PORTB:     rdata_d = {4'h0, portb_q};
			OFS_PORTB_IN:  rdata_d = {4'h0, b_s & portb_q};
			OFS_PORTC_IN:  rdata_d = seg_mode_q ? 8'h00 : {4'h0, c_s};
			OFS_FUNC_SEL:  rdata_d = {6'h00, xc_mode_q, seg_mode_q};
			OFS_PULLUP:    rdata_d = {4'h0, pullup_ctrl_bit_q};
			OFS_KEY_EN:    rdata_d = {4'h0, key_en_q};
			OFS_LCD_DUTY:  rdata_d = {6'h00, duty_q};
			OFS_CYCLES:    rdata_d = machine_cycles;
			default:       rdata_d = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_rd ? rdata_d : 8'h00;
	end

	// Open-drain drivers only ever pull low; a latch one releases the pin
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			out_port_pins_out  <= 8'h00;
			out_port_pins_oe_n <= 8'hff;
			io_port_a_out      <= 4'h0;
			io_port_a_oe_n     <= 4'hf;
			io_port_b_out      <= 4'h0;
			io_port_b_oe_n     <= 4'hf;
		end else begin
			out_port_pins_out  <= 8'h00;
			out_port_pins_oe_n <= portd_q;
			// Crystal mode frees both oscillator pins from the port driver
			if (xc_mode_q) begin
				out_port_pins_oe_n[PIN_XCIN]  <= 1'b1;
				out_port_pins_oe_n[PIN_XCOUT] <= 1'b1;
			end
			io_port_a_out  <= 4'h0;
			io_port_a_oe_n <= porta_q;
			io_port_b_out  <= 4'h0;
			io_port_b_oe_n <= portb_q;
		end
	end

	// Shared interrupt input only sees the pin once its latch is released
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			ext_int_level <= 1'b0;
		else
			ext_int_level <= d_s[PIN_INT] & portd_q[PIN_INT];
	end

	// Key wakeup: a released pin pulled low by a key
	assign key_hit = (~a_s & porta_q) | (~b_s & portb_q & key_en_q);

	// Port A pull-ups are fixed on, port B follows its control bits
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			io_port_a_pullup <= 4'hf;
			io_port_b_pullup <= RST_PULLUP;
			key_wakeup       <= 1'b0;
		end else begin
			io_port_a_pullup <= 4'hf;
			io_port_b_pullup <= pullup_ctrl_bit_q;
			key_wakeup       <= |key_hit;
		end
	end

	// Segment function takes port C pins over as push-pull outputs
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			shared_lcd_segments      <= 4'h0;
			shared_lcd_segments_oe_n <= 4'hf;
		end else begin
			shared_lcd_segments      <= seg_mode_q ? seg_drive : 4'h0;
			shared_lcd_segments_oe_n <= {4{~seg_mode_q}};
		end
	end

	// Commons beyond the duty stay idle
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			lcd_common_lines <= 4'h0;
			lcd_common_en    <= 4'h0;
		end else begin
			lcd_common_lines <= com_drive & duty_mask(duty_q);
			lcd_common_en    <= duty_mask(duty_q);
		end
	end

	// Reset pin: internal causes pull low; outside pull low is reported
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reset_pin_out    <= 1'b0;
			reset_pin_oe_n   <= 1'b1;
			reset_pin_pullup <= 1'b1;
			ext_reset_req    <= 1'b0;
		end else begin
			reset_pin_out    <= 1'b0;
			reset_pin_oe_n   <= ~(wdt_timeout | low_supply);
			reset_pin_pullup <= 1'b1;
			ext_reset_req    <= ~rst_pin_s;
		end
	end

	// Carrier is always driven, never released
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			carrier_out <= 1'b0;
		else
			carrier_out <= carrier_in;
	end
endmodule

// ==== testbench/pcs_port_pins_chk.sv ====
// Checker for the port pin and clock select block.
// Assumes a bind into pcs_port_pins; it sees only that module's ports.
`timescale 1ns/10ps
module pcs_port_pins_chk (
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic       wdt_timeout,
	input wire logic       low_supply,
	input wire logic       reset_pin_out,
	input wire logic       reset_pin_oe_n,
	input wire logic       reset_pin_pullup,
	input wire logic [7:0] out_port_pins_out,
	input wire logic [3:0] io_port_a_out,
	input wire logic [3:0] io_port_b_out,
	input wire logic [3:0] io_port_a_pullup,
	input wire logic [3:0] shared_lcd_segments,
	input wire logic [3:0] shared_lcd_segments_oe_n,
	input wire logic [3:0] lcd_common_lines,
	input wire logic [3:0] lcd_common_en,
	input wire logic       carrier_in,
	input wire logic       carrier_out,
	input wire logic       system_clk,
	input wire logic       instr_clk,
	input wire logic [7:0] machine_cycles
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic [2:0] sc_q;
	logic       arm_q;

	// System ticks since the last instruction tick; the first gap is skipped
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sc_q  <= 3'h0;
			arm_q <= 1'b0;
		end else if (instr_clk) begin
			sc_q  <= 3'h0;
			arm_q <= 1'b1;
		end else begin
			sc_q <= sc_q + {2'h0, system_clk};
		end
	end

	property p_rst_drive;
		!$past(sys_rst) && (wdt_timeout || low_supply) |=> !reset_pin_oe_n;
	endproperty
	a_rst_drive: assert property (p_rst_drive) else $error("reset pin not pulled");
	property p_rst_free;
		!(wdt_timeout || low_supply) |=> reset_pin_oe_n;
	endproperty
	a_rst_free: assert property (p_rst_free) else $error("reset pin held low");
	property p_rst_pin;
		reset_pin_pullup && !reset_pin_out;
	endproperty
	a_rst_pin: assert property (p_rst_pin) else $error("reset pin structure");
	property p_od_low;
		out_port_pins_out == 8'h00 && io_port_a_out == 4'h0 && io_port_b_out == 4'h0;
	endproperty
	a_od_low: assert property (p_od_low) else $error("open drain drives high");
	property p_pa_pull;
		io_port_a_pullup == 4'hf;
	endproperty
	a_pa_pull: assert property (p_pa_pull) else $error("port a pull-up off");
	property p_seg;
		shared_lcd_segments_oe_n == 4'h0
			|| (shared_lcd_segments_oe_n == 4'hf && shared_lcd_segments == 4'h0);
	endproperty
	a_seg: assert property (p_seg) else $error("segment pin mode mixed");
	property p_com;
		!$past(sys_rst, 2) && !$past(sys_rst) |-> lcd_common_en inside {4'h3, 4'h7, 4'hf}
			&& (lcd_common_lines & ~lcd_common_en) == 4'h0;
	endproperty
	a_com: assert property (p_com) else $error("common line outside duty");
	property p_carrier_out;
		!$past(sys_rst, 2) && !$past(sys_rst) |-> carrier_out == $past(carrier_in);
	endproperty
	a_carrier_out: assert property (p_carrier_out) else $error("carrier not followed");
	property p_instr;
		instr_clk && arm_q |-> sc_q + system_clk == 3;
	endproperty
	a_instr: assert property (p_instr) else $error("instruction tick spacing");
	property p_mc;
		!$past(sys_rst, 2) && !$past(sys_rst) && $changed(machine_cycles)
			|-> machine_cycles == $past(machine_cycles) + 8'h1;
	endproperty
	a_mc: assert property (p_mc) else $error("machine cycle count step");
	property p_mc_tick;
		!$past(sys_rst, 2) && !$past(sys_rst) |-> $changed(machine_cycles) == instr_clk;
	endproperty
	a_mc_tick: assert property (p_mc_tick) else $error("machine cycle off tick");
endmodule

bind pcs_port_pins pcs_port_pins_chk u_chk (.*);

// ==== testbench/pcs_far_side.sv ====
// Far side model: resonators, keys, pull-ups, reset and interrupt lines.
// Assumes the block's enables are low while it drives a pin.
`timescale 1ns/10ps
module pcs_far_side (
	input  wire logic       sys_clk,
	input  wire logic       xtal_on,
	input  wire logic       ext_rst_n,
	input  wire logic       int_line,
	input  wire logic [3:0] keys_a,
	input  wire logic [3:0] keys_b,
	input  wire logic       reset_pin_oe_n,
	input  wire logic [7:0] out_port_pins_oe_n,
	input  wire logic [3:0] io_port_a_oe_n,
	input  wire logic [3:0] io_port_a_pullup,
	input  wire logic [3:0] io_port_b_oe_n,
	input  wire logic [3:0] io_port_b_pullup,
	output logic            osc_main_pin,
	output logic            reset_pin_in,
	output logic      [7:0] out_port_pins_in,
	output logic      [3:0] io_port_a_in,
	output logic      [3:0] io_port_b_in
);
	logic osc_sub = 1'b0;
	logic flt_q   = 1'b0;

	// Resonators off the bus clock grid, so edges land at any phase
	initial osc_main_pin = 1'b0;
	always #13 osc_main_pin = ~osc_main_pin;
	always #47 osc_sub = xtal_on & ~osc_sub; // Crystal oscillates only when fitted
	// Released lines with no pull-up wander instead of holding a value
	always @(posedge sys_clk) flt_q <= ~flt_q;
	// Open drain: a driven low wins, then a pressed key, then the pull-up
	assign reset_pin_in = reset_pin_oe_n & ext_rst_n;
	assign out_port_pins_in = out_port_pins_oe_n
		& {1'b1, osc_sub | ~xtal_on, int_line, 5'h1f};
	assign io_port_a_in = io_port_a_oe_n & ~keys_a & (io_port_a_pullup | {4{flt_q}});
	assign io_port_b_in = io_port_b_oe_n & ~keys_b & (io_port_b_pullup | {4{flt_q}});
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the port pin and clock select block.
// Assumes the far side model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module tb;
	import pcs_pkg::*;
	logic       sys_clk, sys_rst, reg_wr, reg_rd, osc_main_pin, system_clk, instr_clk;
	logic       wdt_timeout, low_supply, reset_pin_in, reset_pin_out, reset_pin_oe_n;
	logic       reset_pin_pullup, ext_reset_req, ext_int_level, key_wakeup, carrier_in;
	logic       carrier_out, xtal_on, ext_rst_n, int_line, c;
	logic       rd_d = 1'b0;
	logic [3:0] reg_addr, io_port_a_in, io_port_a_out, io_port_a_oe_n, io_port_a_pullup;
	logic [3:0] io_port_b_in, io_port_b_out, io_port_b_oe_n, io_port_b_pullup, keys_a, keys_b;
	logic [3:0] in_port_c_in, seg_drive, shared_lcd_segments, shared_lcd_segments_oe_n;
	logic [3:0] com_drive, lcd_common_lines, lcd_common_en, a4, d4;
	logic [7:0] reg_wdata, reg_rdata, machine_cycles, out_port_pins_in, out_port_pins_out;
	logic [7:0] out_port_pins_oe_n, m, mcnt;
	logic [7:0] cs [4] = '{8'h00, 8'h01, 8'h09, 8'h08};
	logic [3:0] dm [4] = '{4'h3, 4'h7, 4'hf, 4'hf};
	logic [2:0] rs [4] = '{3'b101, 3'b011, 3'b000, 3'b001};
	logic [7:0] exp_q [$];
	int         n_errors, checks_done, cyc;

	pcs_port_pins DUT (.*);
	pcs_far_side far (.*);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic end_sim;
		$display("mismatches %0d of %0d checks", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t seen %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		wt(1);
		reg_wr <= 1'b0;
		wt(1);
	endtask

	// The expected word waits in the queue until the data cycle
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		wt(1);
		reg_rd <= 1'b0;
		wt(1);
	endtask

	// Counts source edges against system and instruction ticks; the pins are async
	task automatic meas(input int div, input logic sub);
		int ns, ni, nsrc;
		logic p, s;
		ns = 0;
		ni = 0;
		nsrc = 0;
		p = 1'b1;
		wt(20);
		repeat (600) begin
			wt(1);
			s = sub ? out_port_pins_in[PIN_XCIN] : osc_main_pin;
			nsrc += (s && !p);
			p = s;
			ns += system_clk;
			ni += instr_clk;
		end
		chk(8'(ns * div >= nsrc - div - 2 && ns * div <= nsrc + div + 2), 8'h01);
		chk(8'(3 * ni >= ns - 3 && 3 * ni <= ns + 3), 8'h01);
	endtask

	// Read data stand one cycle after the strobe
	always @(posedge sys_clk) begin
		if (rd_d) chk(reg_rdata, exp_q.pop_front());
		rd_d <= reg_rd;
	end

	// Instruction clock periods since reset, one machine cycle each
	always @(posedge sys_clk) mcnt <= sys_rst ? 8'h00 : mcnt + {7'h00, instr_clk};

	// Hang guard far above the run of some 3400 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			end_sim;
		end
	end

	initial begin
		{sys_rst, ext_rst_n, int_line} = 3'h7;
		{reg_wr, reg_rd, wdt_timeout, low_supply, carrier_in, xtal_on} = 6'h0;
		{reg_addr, keys_a, keys_b, in_port_c_in, seg_drive, com_drive} = 24'h0;
		reg_wdata = 8'h00;
		void'($urandom(5880));
		wt(16);
		sys_rst <= 1'b0;
		wt(1);
		rd(OFS_CLK_CTRL, 8'h08);
		rd(OFS_PORTD, 8'hff);
		wr(4'hf, 8'hff);
		rd(4'he, 8'h00);
		chk({io_port_a_oe_n, io_port_b_oe_n}, 8'hff);
		meas(4, 1'b0);
		xtal_on <= 1'b1;
		wr(OFS_FUNC_SEL, 8'h02);
		foreach (cs[i]) begin
			wr(OFS_CLK_CTRL, cs[i]);
			rd(OFS_CLK_CTRL, cs[i]);
			meas(cs[i][3] ? 4 : 1, cs[i][0]);
		end
		wr(OFS_PORTD, 8'h00);
		wt(3);
		chk(out_port_pins_oe_n, 8'hc0);
		wr(OFS_FUNC_SEL, 8'h00);
		xtal_on <= 1'b0;
		// Sub source with no crystal stops the ticks, so the count holds still
		wr(OFS_CLK_CTRL, 8'h01);
		wt(3);
		rd(OFS_CYCLES, mcnt);
		chk(machine_cycles, mcnt);
		m = 8'($urandom);
		wr(OFS_PORTD, m);
		for (int i = 0; i < 8; i++) begin
			c = 1'($urandom);
			m[i] = c;
			wr(OFS_DPTR_Y, 8'(i));
			wr(OFS_PORTD_BIT, {7'h0, c});
			rd(OFS_PORTD_BIT, {7'h0, c});
		end
		rd(OFS_PORTD, m);
		wr(OFS_PORTD, m);
		chk(out_port_pins_oe_n, m);
		wr(OFS_DPTR_Y, 8'h05);
		wr(OFS_PORTD_BIT, 8'h01);
		for (int i = 0; i < 2; i++) begin
			int_line <= i[0];
			wt(5);
			chk(ext_int_level, 8'(i));
		end
		a4 = 4'($urandom) | 4'h1;
		wr(OFS_PORTA, {4'h0, a4});
		wt(3);
		chk(io_port_a_oe_n, a4);
		rd(OFS_PORTA_IN, {4'h0, a4});
		keys_a <= 4'hf;
		wt(5);
		chk(key_wakeup, 8'h01);
		rd(OFS_PORTA_IN, 8'h00);
		keys_a <= 4'h0;
		wr(OFS_PORTB, 8'h0f);
		wr(OFS_PULLUP, 8'h0f);
		wr(OFS_KEY_EN, 8'h0f);
		d4 = 4'($urandom) | 4'h1;
		keys_b <= d4;
		wt(5);
		chk(io_port_b_pullup, 8'h0f);
		chk(key_wakeup, 8'h01);
		rd(OFS_PORTB_IN, {4'h0, ~d4});
		wr(OFS_KEY_EN, 8'h00);
		wr(OFS_PULLUP, 8'h00);
		wt(5);
		chk(io_port_b_pullup, 8'h00);
		chk(key_wakeup, 8'h00);
		keys_b <= 4'h0;
		for (int i = 0; i < 2; i++) begin
			d4 = 4'($urandom);
			seg_drive <= d4;
			in_port_c_in <= ~d4;
			wr(OFS_FUNC_SEL, 8'(i));
			wt(5);
			chk(shared_lcd_segments, i ? d4 : 4'h0);
			chk(shared_lcd_segments_oe_n, i ? 4'h0 : 4'hf);
			rd(OFS_PORTC_IN, i ? 8'h00 : {4'h0, ~d4});
		end
		foreach (dm[i]) begin
			wr(OFS_LCD_DUTY, 8'(i));
			com_drive <= 4'($urandom);
			wt(3);
			chk(lcd_common_en, dm[i]);
			chk(lcd_common_lines, com_drive & dm[i]);
		end
		foreach (rs[i]) begin
			{wdt_timeout, low_supply, ext_rst_n} <= rs[i];
			wt(5);
			chk(reset_pin_oe_n, ~|rs[i][2:1]);
			chk(ext_reset_req, rs[i] != 3'b001);
		end
		repeat (8) begin
			c = 1'($urandom);
			carrier_in <= c;
			wt(2);
			chk(carrier_out, c);
		end
		sys_rst <= 1'b1;
		wt(16);
		sys_rst <= 1'b0;
		wt(1);
		rd(OFS_CLK_CTRL, 8'h08);
		chk(out_port_pins_oe_n, 8'hff);
		wt(4);
		end_sim;
	end
endmodule
